// ### inc/extint_map.svh
`ifndef EXTINT_MAP_SVH
`define EXTINT_MAP_SVH
// ==========================================================================
// Register map
// ==========================================================================
// Status/control register index; byte address is four times it
`define EXTINT_SCR_INDEX 6'h1a
// Field positions inside the status/control register
`define EXTINT_BIT_PEND 3
`define EXTINT_BIT_ACK 2
`define EXTINT_BIT_MASK 1
`define EXTINT_BIT_SENS 0
// Reset values of the writable fields
`define EXTINT_RST_MASK 1'b0
`define EXTINT_RST_SENS 1'b0
// ==========================================================================
// Bus answers and vector
// ==========================================================================
`define EXTINT_RESP_OKAY 2'h0
`define EXTINT_RESP_SLVERR 2'h2
// Vector locations for this request, high byte then low byte
`define EXTINT_VECTOR_HI 16'hfffa
`define EXTINT_VECTOR_LO 16'hfffb
// Pin idle level, loaded into the registered pin level output at reset
`define EXTINT_PIN_IDLE 1'b1
`endif

// ### inc/extint_pkg.sv
// ==========================================================================
// Types shared by the external interrupt latch
// ==========================================================================
package extint_pkg;
  // Latch states, Gray coded along idle -> pending -> acknowledged
  typedef enum logic [1:0] {
    EXTINT_IDLE = 2'b00,
    EXTINT_PEND = 2'b01,
    EXTINT_ACKD = 2'b11
  } extint_state_t;
endpackage : extint_pkg

// ### src/extint_sync.sv
`timescale 1ns/1ps
`include "extint_map.svh"
// ==========================================================================
// Pin synchroniser and falling-edge detector
// ==========================================================================
module extint_sync
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic level,
  output logic fall
);
  // First stage, read by the second stage and, in reset, also by prev_q
  logic meta_q;
  logic meta_d;
  // Second stage, the clean level
  logic sync_q;
  logic sync_d;
  // Previous clean level for the edge compare
  logic prev_q;
  logic prev_d;

  // Next values of the chain
  always_comb
  begin
    meta_d = pin_n;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // A pin already low when reset ends must not read as a fresh edge,
  // so the chain keeps tracking the pin while the compare is held equal
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= sync_d;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Falling edge from two clean samples
  assign level = sync_q;
  assign fall = prev_q & ~sync_q;
endmodule : extint_sync

// ### src/extint_latch.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "extint_map.svh"
module extint_latch
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // External interrupt pin, active low
  input wire logic irq_pin_n,
  // Acknowledge pulse from the vector fetch of this interrupt
  input wire logic vector_fetch_ack,
  // Processor global interrupt mask
  input wire logic cpu_int_mask,
  // Break state and its clear enable from system integration
  input wire logic break_active,
  input wire logic break_clear_enable,
  // Request to the priority logic
  output logic irq_request,
  // Present pin level for the branch-on-pin instructions
  output logic pin_level,
  // Vector locations presented with the request
  output logic [15:0] vector_addr_hi,
  output logic [15:0] vector_addr_lo,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ========================================================================
  // Pin conditioning
  // ========================================================================
  // Clean pin level, high when idle
  logic pin_sync;
  // One-cycle pulse on a falling edge
  logic pin_fall;

  extint_sync u_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pin_n(irq_pin_n),
    .level(pin_sync),
    .fall(pin_fall)
  );

  // ========================================================================
  // Bus slave state
  // ========================================================================
  // Write address held until paired with data
  logic aw_have_q;
  logic aw_have_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  // Write data held until paired with address
  logic w_have_q;
  logic w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  // Channel outputs, all registered
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Write commit strobes seen by the register logic
  logic wr_commit;
  logic wr_hit;

  // ========================================================================
  // Interrupt core state
  // ========================================================================
  // Latch state machine
  extint_pkg::extint_state_t state_q;
  extint_pkg::extint_state_t state_d;
  // Writable control bits
  logic mask_q;
  logic mask_d;
  logic sens_q;
  logic sens_d;
  // Registered outputs
  logic req_q;
  logic req_d;
  logic pin_q;
  logic pin_d;
  // Software acknowledge after break gating
  logic sw_ack;
  // Any acknowledge this cycle
  logic any_ack;
  // Latch holds a request
  logic latched;

  // ========================================================================
  // Bus slave next values
  // ========================================================================
  // Address and data are taken in either order; the write lands
  // once both are held and no response is outstanding
  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    wr_commit = 1'b0;
    wr_hit = 1'b0;
    // Capture write address
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    // Capture write data
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    // Retire the response
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    // Commit a paired write
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      wr_commit = 1'b1;
      wr_hit = (aw_addr_q[ADDR_W-1:2] == (ADDR_W-2)'(`EXTINT_SCR_INDEX));
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      // Unmapped address gets an error, no state changes
      bresp_d = wr_hit ? `EXTINT_RESP_OKAY : `EXTINT_RESP_SLVERR;
    end
    // Read: one in flight, answered the cycle after it is taken
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(`EXTINT_SCR_INDEX))
      begin
        rresp_d = `EXTINT_RESP_OKAY;
        // Upper bits and acknowledge read zero
        rdata_d[`EXTINT_BIT_PEND] = latched;
        rdata_d[`EXTINT_BIT_MASK] = mask_q;
        rdata_d[`EXTINT_BIT_SENS] = sens_q;
      end
      else
      begin
        rresp_d = `EXTINT_RESP_SLVERR;
      end
    end
    // Ready only while the matching slot is free
    awready_d = !aw_have_d && !(aw_have_q && w_have_q);
    wready_d = !w_have_d && !(aw_have_q && w_have_q);
    // First cycle out of reset: nothing in flight, open the read slot
    if (!arready_q && !rvalid_q)
    begin
      arready_d = 1'b1;
    end
  end

  // Bus slave registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `EXTINT_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `EXTINT_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Interrupt core next values
  // ========================================================================
  assign latched = (state_q != extint_pkg::EXTINT_IDLE);

  // Register fields take effect only through the low byte lane
  always_comb
  begin
    mask_d = mask_q;
    sens_d = sens_q;
    sw_ack = 1'b0;
    if (wr_commit && wr_hit && w_strb_q[0])
    begin
      mask_d = w_data_q[`EXTINT_BIT_MASK];
      sens_d = w_data_q[`EXTINT_BIT_SENS];
      // Break protects the latch from software acknowledge unless clearing is enabled
      sw_ack = w_data_q[`EXTINT_BIT_ACK] && (!break_active || break_clear_enable);
    end
    any_ack = sw_ack || vector_fetch_ack;
  end

  // Latch state; a new edge always beats a clear in the same cycle
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      extint_pkg::EXTINT_IDLE:
      begin
        // Edge sets in either mode
        if (pin_fall)
        begin
          state_d = extint_pkg::EXTINT_PEND;
        end
      end
      extint_pkg::EXTINT_PEND:
      begin
        if (pin_fall)
        begin
          state_d = extint_pkg::EXTINT_PEND;
        end
        else if (any_ack && (!sens_q || pin_sync))
        begin
          // Edge mode clears at once; level mode once the pin is high
          state_d = extint_pkg::EXTINT_IDLE;
        end
        else if (any_ack)
        begin
          // Pin still low: remember the acknowledge, keep pending
          state_d = extint_pkg::EXTINT_ACKD;
        end
      end
      extint_pkg::EXTINT_ACKD:
      begin
        if (pin_fall)
        begin
          state_d = extint_pkg::EXTINT_PEND;
        end
        else if (pin_sync || !sens_q)
        begin
          // Pin back high after the acknowledge
          state_d = extint_pkg::EXTINT_IDLE;
        end
      end
      default:
      begin
        state_d = extint_pkg::EXTINT_IDLE;
      end
    endcase
    // Both masks gate the request, not the latch
    req_d = (state_d != extint_pkg::EXTINT_IDLE) && !mask_d && !cpu_int_mask;
    pin_d = pin_sync;
  end

  // Interrupt core registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // Reset drops any request even with the pin low
      state_q <= extint_pkg::EXTINT_IDLE;
      mask_q <= `EXTINT_RST_MASK;
      sens_q <= `EXTINT_RST_SENS;
      req_q <= 1'b0;
      pin_q <= `EXTINT_PIN_IDLE;
    end
    else
    begin
      state_q <= state_d;
      mask_q <= mask_d;
      sens_q <= sens_d;
      req_q <= req_d;
      pin_q <= pin_d;
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops except the constant vector locations
  // ========================================================================
  assign irq_request = req_q;
  assign pin_level = pin_q;
  // Fixed vector locations; constants, so no flop is needed
  assign vector_addr_hi = `EXTINT_VECTOR_HI;
  assign vector_addr_lo = `EXTINT_VECTOR_LO;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
endmodule : extint_latch

// ### verif/extint_latch_chk.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks for the external interrupt latch
// ==========================================================================
module extint_latch_chk
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_pin_n,
  input wire logic vector_fetch_ack,
  input wire logic cpu_int_mask,
  input wire logic irq_request,
  input wire logic pin_level,
  input wire logic [15:0] vector_addr_hi,
  input wire logic [15:0] vector_addr_lo,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles since reset, saturating; $past must not reach into reset
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  // Next count
  always_comb
  begin
    settle_d = settle_q;
    if (rst)
      settle_d = 2'h0;
    else if (settle_q != 2'h3)
      settle_d = settle_q + 2'h1;
  end
  // Register count
  always_ff @(posedge core_clk)
    settle_q <= settle_d;
  // ========================================================================
  // Assertions
  // ========================================================================
  chk_vector_const:
    assert property (vector_addr_hi == 16'hfffa && vector_addr_lo == 16'hfffb) else $error("vector address wrong");
  chk_pin_follow:
    assert property (settle_q == 2'h3 |-> pin_level == $past(irq_pin_n, 3)) else $error("pin level lags wrong");
  chk_cpu_mask:
    assert property (cpu_int_mask |=> !irq_request) else $error("request passed global mask");
  chk_fetch_clear:
    assert property (irq_pin_n [*4] ##0 vector_fetch_ack |-> ##[1:2] !irq_request) else $error("fetch did not clear");
  chk_ack_reads_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[2] == 1'b0 && s_axi_rdata[31:4] == 28'h0) else $error("ack or upper set");
  chk_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_bresp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  chk_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while data pending");
endmodule : extint_latch_chk

bind extint_latch extint_latch_chk extint_latch_chk_i
(
  .core_clk, .rst, .irq_pin_n, .vector_fetch_ack, .cpu_int_mask, .irq_request, .pin_level,
  .vector_addr_hi, .vector_addr_lo, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ### verif/extint_pin_drv.sv
`timescale 1ns/1ps
// ==========================================================================
// External device on the active-low interrupt pin
// ==========================================================================
module extint_pin_drv
(
  input wire logic core_clk,
  input wire logic pull_low,
  output logic pin_n
);
  // Pin idles high through its pull-up
  initial pin_n = 1'b1;
  // Device moves the pin one edge after being told, never mid-cycle
  always @(posedge core_clk)
    pin_n <= !pull_low;
endmodule : extint_pin_drv

// ### verif/tb.sv
`timescale 1ns/1ps
`include "extint_map.svh"
// ==========================================================================
// Self-checking bench
// ==========================================================================
module tb;
  typedef struct {string nm; logic [31:0] v; logic [1:0] r;} extint_exp_t;
  localparam logic [7:0] SCR = {`EXTINT_SCR_INDEX, 2'h0};
  localparam logic [7:0] PND = 8'h1 << `EXTINT_BIT_PEND;
  localparam logic [7:0] ACK = 8'h1 << `EXTINT_BIT_ACK;
  localparam logic [7:0] MSK = 8'h1 << `EXTINT_BIT_MASK;
  localparam logic [7:0] SEL = 8'h1 << `EXTINT_BIT_SENS;
  localparam logic [1:0] OK = `EXTINT_RESP_OKAY;
  logic core_clk, rst = 1'b1, pull_low = 1'b0, irq_pin_n, vector_fetch_ack = 1'b0, cpu_int_mask = 1'b0;
  logic break_active = 1'b0, break_clear_enable = 1'b0, irq_request, pin_level;
  logic [15:0] vector_addr_hi, vector_addr_lo;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0, n_compared = 0, cycles = 0;
  extint_exp_t q[$];
  extint_exp_t note;
  extint_latch #(.ADDR_W(8)) extint_latch_i (.*);
  extint_pin_drv extint_pin_drv_i (.core_clk(core_clk), .pull_low(pull_low), .pin_n(irq_pin_n));
  // 50 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic see(input string nm, input logic v, input logic e);
    chk(nm, {31'h0, v}, {31'h0, e});
  endtask : see
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Pin change, then time for sync, edge and request
  task automatic pin_set(input logic lvl);
    pull_low <= !lvl;
    cyc(6);
  endtask : pin_set
  // One-cycle vector fetch acknowledge
  task automatic fetch;
    vector_fetch_ack <= 1'b1;
    cyc(1);
    vector_fetch_ack <= 1'b0;
    cyc(2);
  endtask : fetch
  // Write; upper data and strobes random, bready late to test holding
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    logic aw, w;
    q.push_back('{"bresp", {30'h0, rsp}, rsp});
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= {3'($urandom), 1'b1};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    cyc($urandom_range(1, 2));
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read; the answer is compared by the monitor
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    q.push_back('{nm, {24'h0, e}, (a == SCR) ? OK : `EXTINT_RESP_SLVERR});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    cyc($urandom_range(1, 2));
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Oldest note against each answer taken
  always @(posedge core_clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      note = q.pop_front();
      chk(note.nm, s_axi_rdata, note.v);
      chk({note.nm, " rresp"}, {30'h0, s_axi_rresp}, {30'h0, note.r});
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      note = q.pop_front();
      chk(note.nm, {30'h0, s_axi_bresp}, note.v);
    end
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      results();
    end
  end
  // ========================================================================
  // Main sequence
  // ========================================================================
  initial
  begin
    void'($urandom(32'h5804f6aa));
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    see("pin_level", pin_level, 1'b1);
    wr(8'h6c, 8'hff, `EXTINT_RESP_SLVERR);
    rd("unmapped", 8'h6c, 8'h00);
    rd("reset", SCR, 8'h00);
    // Edge mode: set, clear by software with pin low, re-arm, fetch
    pin_set(1'b0);
    see("request", irq_request, 1'b1);
    see("pin_level", pin_level, 1'b0);
    rd("pending", SCR, PND);
    wr(SCR, ACK, OK);
    rd("edge ack", SCR, 8'h00);
    pin_set(1'b1);
    pin_set(1'b0);
    rd("re-arm", SCR, PND);
    fetch();
    see("fetch", irq_request, 1'b0);
    rd("fetch", SCR, 8'h00);
    pin_set(1'b1);
    // Local mask hides the request but not the flag
    wr(SCR, MSK, OK);
    pin_set(1'b0);
    see("masked", irq_request, 1'b0);
    rd("masked", SCR, PND | MSK);
    wr(SCR, 8'h00, OK);
    cyc(2);
    see("unmasked", irq_request, 1'b1);
    cpu_int_mask <= 1'b1;
    cyc(2);
    see("cpu mask", irq_request, 1'b0);
    cpu_int_mask <= 1'b0;
    pin_set(1'b1);
    wr(SCR, ACK, OK);
    // Level mode: acknowledge before and after the pin returns
    wr(SCR, SEL, OK);
    pin_set(1'b0);
    wr(SCR, ACK | SEL, OK);
    rd("level held", SCR, PND | SEL);
    pin_set(1'b1);
    rd("level done", SCR, SEL);
    pin_set(1'b0);
    pin_set(1'b1);
    rd("level pin up", SCR, PND | SEL);
    fetch();
    rd("level fetch", SCR, SEL);
    // Break state guards the latch against software acknowledge unless clearing is enabled
    wr(SCR, 8'h00, OK);
    break_active <= 1'b1;
    pin_set(1'b0);
    pin_set(1'b1);
    wr(SCR, ACK, OK);
    rd("break hold", SCR, PND);
    break_clear_enable <= 1'b1;
    wr(SCR, ACK, OK);
    break_active <= 1'b0;
    cyc(2);
    rd("break clear", SCR, 8'h00);
    break_clear_enable <= 1'b0;
    // Reset with a pending level request and the pin low
    wr(SCR, SEL, OK);
    pin_set(1'b0);
    rst <= 1'b1;
    cyc(2);
    see("reset req", irq_request, 1'b0);
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    // Pin still low across the release: no new request may appear
    rd("after reset", SCR, 8'h00);
    see("reset low pin", irq_request, 1'b0);
    pull_low <= 1'b0;
    cyc(6);
    rd("pin up after reset", SCR, 8'h00);
    results();
  end
endmodule : tb
